/* File: rtl/dac_calibration_trim_regs.v */
/*
  Calibration trim register bank of the high speed excitation DAC:
  write key, gain trim, four offset trims, DAC configuration and a
  status word, plus the path that applies the trims to each DAC code.
  Assumes a simple register port synchronous to mclk_i, one strobe at a
  time, and a DAC power mode level from the power controller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dac_trim_defs.vh"

module dac_calibration_trim_regs
(
  input  wire                 mclk_i,
  input  wire                 sys_rst_i,
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [`DATA_W-1:0]   wdata_i,
  input  wire                 wr_i,
  input  wire                 rd_i,
  input  wire                 hs_mode_i,
  input  wire [`TRIM_W-1:0]   dac_code_i,
  output reg  [`DATA_W-1:0]   rdata_o,
  output wire [`OUT_W-1:0]    dac_out_o,
  output wire                 gain_sel_o,
  output wire                 atten_en_o,
  output wire [7:0]           update_rate_o,
  output wire                 cal_unlocked_o
);

  // Offset trim entries, in this index order
  localparam [1:0] IDX_ATTEN_LP   = 2'd0;
  localparam [1:0] IDX_NOATTEN_LP = 2'd1;
  localparam [1:0] IDX_ATTEN_HS   = 2'd2;
  localparam [1:0] IDX_NOATTEN_HS = 2'd3;

  reg  [`DATA_W-1:0]  key_reg;
  reg  [`TRIM_W-1:0]  gain_trim_reg;
  reg  [`CFG_W-1:0]   cfg_reg;
  reg                 unlocked_reg;
  reg                 reject_reg;
  reg                 reject_next;
  reg  [`TRIM_W-1:0]  sel_offset_reg;
  reg  [`TRIM_W-1:0]  code_reg;
  reg  [`DATA_W-1:0]  rdata_next;
  wire                unlocked;
  wire                hit_key;
  wire                hit_gain;
  wire                hit_cfg;
  wire                hit_status;
  wire [3:0]          hit_ofs;
  wire [3:0]          prot_ofs;
  wire [3:0]          wr_ofs;
  wire [3:0]          rej_ofs;
  wire                wr_gain;
  wire                rej_gain;
  wire [1:0]          ofs_sel;
  wire [`TRIM_W-1:0]  ofs_val [0:3];

  // Key comparison against the stored word, not the bus value, so the
  // unlock takes effect on the cycle after the key write
  assign unlocked = (key_reg == `CAL_KEY_UNLOCK);

  // Address decode
  assign hit_key    = (addr_i == `OFS_CAL_KEY);
  assign hit_gain   = (addr_i == `OFS_GAIN_TRIM);
  assign hit_cfg    = (addr_i == `OFS_FAST_DAC_CFG);
  assign hit_status = (addr_i == `OFS_CAL_STATUS);

  // Gain trim write gated by the key
  assign wr_gain  = wr_i & hit_gain & unlocked;
  assign rej_gain = wr_i & hit_gain & ~unlocked;

  // Key register: any write stores the word; only the exact key unlocks,
  // so writing any other value locks the bank again
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      key_reg <= `CAL_KEY_RST;
    else if (wr_i & hit_key)
      key_reg <= wdata_i;
  end

  // Registered copy of the lock state for the output pin
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      unlocked_reg <= 1'b0;
    else
      unlocked_reg <= unlocked;
  end

  // Gain trim: twelve bits only, upper write bits dropped
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      gain_trim_reg <= `GAIN_TRIM_RST;
    else if (wr_gain)
      gain_trim_reg <= wdata_i[`TRIM_W-1:0];
  end

  // DAC configuration: gain select, update rate and attenuator enable
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      cfg_reg <= `FAST_DAC_CFG_RST;
    else if (wr_i & hit_cfg)
      cfg_reg <= wdata_i[`CFG_W-1:0];
  end

  // Offset trims: one entry each, protection per entry.
  // Low power trims carry no key protection; high speed ones do.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_ofs
      reg [`TRIM_W-1:0] trim_reg;

      assign hit_ofs[gi]  = (addr_i == ofs_addr(gi));
      assign prot_ofs[gi] = (gi == IDX_ATTEN_HS) || (gi == IDX_NOATTEN_HS);
      assign wr_ofs[gi]   = wr_i & hit_ofs[gi] & (unlocked | ~prot_ofs[gi]);
      assign rej_ofs[gi]  = wr_i & hit_ofs[gi] & ~unlocked & prot_ofs[gi];
      assign ofs_val[gi]  = trim_reg;

      // Zero at reset means no offset shift
      always @(posedge mclk_i)
      begin
        if (sys_rst_i)
          trim_reg <= `OFFSET_TRIM_RST;
        else if (wr_ofs[gi])
          trim_reg <= wdata_i[`TRIM_W-1:0];
      end
    end
  endgenerate

  // Byte address of each offset trim entry
  function [`ADDR_W-1:0] ofs_addr;
    input integer idx;
    begin
      case (idx)
        0:       ofs_addr = `OFS_ATTEN_LP;
        1:       ofs_addr = `OFS_NOATTEN_LP;
        2:       ofs_addr = `OFS_ATTEN_HS;
        default: ofs_addr = `OFS_NOATTEN_HS;
      endcase
    end
  endfunction

  // Sticky flag for a refused calibration write; a new refusal in the
  // clearing cycle wins so no refusal goes unseen
  always @*
  begin
    reject_next = reject_reg;
    if (wr_i & hit_status & wdata_i[`STAT_REJECT_BIT])
      reject_next = 1'b0;
    if (rej_gain | (|rej_ofs))
      reject_next = 1'b1;
  end

  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      reject_reg <= 1'b0;
    else
      reject_reg <= reject_next;
  end

  // Offset selection: power mode picks low power or high speed, the
  // attenuator bit picks the attenuated or unattenuated entry
  assign ofs_sel = {hs_mode_i, ~cfg_reg[`CFG_ATTEN_BIT]};

  // Selected offset registered to keep the decode out of the multiplier path.
  // After a range change the matching stored trim is selected on the next clock, with no rewrite.
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sel_offset_reg <= `OFFSET_TRIM_RST;
      code_reg       <= 12'h800;
    end
    else
    begin
      case (ofs_sel)
        IDX_ATTEN_LP:   sel_offset_reg <= ofs_val[0];
        IDX_NOATTEN_LP: sel_offset_reg <= ofs_val[1];
        IDX_ATTEN_HS:   sel_offset_reg <= ofs_val[2];
        IDX_NOATTEN_HS: sel_offset_reg <= ofs_val[3];
        default:        sel_offset_reg <= `OFFSET_TRIM_RST;
      endcase
      code_reg <= dac_code_i;
    end
  end

  // Trim arithmetic: one gain trim for all ranges, offset in half-LSB
  // steps so code 1 adds half an LSB and all ones removes half an LSB
  dac_trim_apply u_apply
  (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .code_i    (code_reg),
    .gain_i    (gain_trim_reg),
    .offset_i  (sel_offset_reg),
    .code_o    (dac_out_o)
  );

  // Read mux: trims return zero above bit 11, unmapped reads zero
  always @*
  begin
    rdata_next = 32'h00000000;
    if (rd_i)
    begin
      case (addr_i)
        `OFS_CAL_KEY:
          rdata_next = key_reg;
        `OFS_GAIN_TRIM:
          rdata_next = {20'h00000, gain_trim_reg};
        `OFS_ATTEN_LP:
          rdata_next = {20'h00000, ofs_val[0]};
        `OFS_NOATTEN_LP:
          rdata_next = {20'h00000, ofs_val[1]};
        `OFS_ATTEN_HS:
          rdata_next = {20'h00000, ofs_val[2]};
        `OFS_NOATTEN_HS:
          rdata_next = {20'h00000, ofs_val[3]};
        `OFS_FAST_DAC_CFG:
          rdata_next = {19'h00000, cfg_reg};
        `OFS_CAL_STATUS:
          rdata_next = {30'h00000000, reject_reg, unlocked};
        default:
          rdata_next = 32'h00000000;
      endcase
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      rdata_o <= 32'h00000000;
    else
      rdata_o <= rdata_next;
  end

  // Range bits out to the analog side, straight from the register
  assign gain_sel_o     = cfg_reg[`CFG_GAIN_SEL_BIT];
  assign atten_en_o     = cfg_reg[`CFG_ATTEN_BIT];
  assign update_rate_o  = cfg_reg[`CFG_RATE_HI:`CFG_RATE_LO];
  assign cal_unlocked_o = unlocked_reg;

endmodule
`default_nettype wire

/* File: rtl/dac_trim_defs.vh */
/*
  Constants of the excitation DAC calibration trim bank: register byte
  offsets, field positions, reset values and the trim arithmetic scale.
  Assumes it is included by its bare name from the rtl files.
*/
`ifndef DAC_TRIM_DEFS_VH
`define DAC_TRIM_DEFS_VH

// Register bus geometry
`define ADDR_W            16
`define DATA_W            32
`define TRIM_W            12

// Register byte offsets
`define OFS_FAST_DAC_CFG  16'h2010
`define OFS_CAL_KEY       16'h2230
`define OFS_CAL_STATUS    16'h2240
`define OFS_GAIN_TRIM     16'h2260
`define OFS_ATTEN_LP      16'h2264
`define OFS_NOATTEN_LP    16'h2268
`define OFS_ATTEN_HS      16'h22b8
`define OFS_NOATTEN_HS    16'h22bc

// Key values
`define CAL_KEY_UNLOCK    32'hde87a5af
`define CAL_KEY_RST       32'hde87a5a0

// Reset values
`define GAIN_TRIM_RST     12'h800
`define OFFSET_TRIM_RST   12'h000
`define FAST_DAC_CFG_RST  13'h001e

// Configuration field positions
`define CFG_GAIN_SEL_BIT  12
`define CFG_RATE_HI       8
`define CFG_RATE_LO       1
`define CFG_ATTEN_BIT     0
`define CFG_W             13

// Status field positions
`define STAT_UNLOCKED_BIT 0
`define STAT_REJECT_BIT   1

// Trim arithmetic
`define GAIN_MID          13'h0800
`define CODE_MID          13'h0800
`define GAIN_TRIM_SHIFT   13
`define OUT_W             13
`define OUT_MID_HALF      16'h1000
`define OUT_MAX_HALF      16'h1fff

`endif

/* File: rtl/dac_trim_apply.v */
/*
  Two-stage pipeline that applies the gain trim and the selected offset
  trim to a 12-bit DAC code. Result is in half-LSB units, 13 bits.
  Assumes trims are stable or change between codes; latency 2 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dac_trim_defs.vh"

module dac_trim_apply
(
  input  wire                 mclk_i,
  input  wire                 sys_rst_i,
  input  wire [`TRIM_W-1:0]   code_i,
  input  wire [`TRIM_W-1:0]   gain_i,
  input  wire [`TRIM_W-1:0]   offset_i,
  output reg  [`OUT_W-1:0]    code_o
);

  wire signed [12:0] code_cen;
  wire signed [12:0] gain_dev;
  wire signed [25:0] prod;
  reg  signed [25:0] prod_reg;
  reg  signed [13:0] code_half_reg;
  reg  signed [11:0] offset_reg;
  wire signed [15:0] sum;

  // Code and gain both centred on midscale; gain 0x800 means unity
  assign code_cen = $signed({1'b0, code_i} - `CODE_MID);
  assign gain_dev = $signed({1'b0, gain_i} - `GAIN_MID);
  assign prod     = code_cen * gain_dev;

  // Offset is already in half-LSB units, so the code is doubled to match
  assign sum = {{2{code_half_reg[13]}}, code_half_reg}
             + {{3{prod_reg[25]}}, prod_reg[25:`GAIN_TRIM_SHIFT]}
             + {{4{offset_reg[11]}}, offset_reg}
             + $signed(`OUT_MID_HALF);

  // Stage one: product and doubled code
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      prod_reg      <= 26'h0000000;
      code_half_reg <= 14'h0000;
      offset_reg    <= 12'h000;
    end
    else
    begin
      prod_reg      <= prod;
      code_half_reg <= {code_cen, 1'b0};
      offset_reg    <= offset_i;
    end
  end

  // Stage two: saturate so a large trim never wraps the output round
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      code_o <= 13'h1000;
    else if (sum < 16'sh0000)
      code_o <= 13'h0000;
    else if (sum > $signed(`OUT_MAX_HALF))
      code_o <= 13'h1fff;
    else
      code_o <= sum[`OUT_W-1:0];
  end

endmodule
`default_nettype wire

/* File: testbench/trim_bank_checker.sv */
/* Port assertions for the DAC trim register bank.
   Assumes it is bound to dac_calibration_trim_regs, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "dac_trim_defs.vh"
module trim_bank_checker
(
  input wire logic               mclk_i,
  input wire logic               sys_rst_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic               hs_mode_i,
  input wire logic [`TRIM_W-1:0] dac_code_i,
  input wire logic [`DATA_W-1:0] rdata_o,
  input wire logic [`OUT_W-1:0]  dac_out_o,
  input wire logic               gain_sel_o,
  input wire logic               atten_en_o,
  input wire logic [7:0]         update_rate_o,
  input wire logic               cal_unlocked_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Exact decode, the bank has no aliases
  wire logic       key_wr = wr_i && addr_i == `OFS_CAL_KEY;
  wire logic       cfg_wr = wr_i && addr_i == `OFS_FAST_DAC_CFG;
  wire logic [9:0] cfg_w  = {wdata_i[12], wdata_i[8:0]};
  // Flag trails the key register by one cycle
  sequence s_unlock;
    key_wr && wdata_i == `CAL_KEY_UNLOCK ##1 1'b1;
  endsequence
  sequence s_relock;
    key_wr && wdata_i != `CAL_KEY_UNLOCK ##1 1'b1;
  endsequence
  sequence s_calm;
    !wr_i && $stable(dac_code_i) && $stable(hs_mode_i);
  endsequence
  chk_key_opens: assert property (s_unlock |=> cal_unlocked_o)
    else $error("unlock flag low after key");
  chk_key_closes: assert property (s_relock |=> !cal_unlocked_o)
    else $error("unlock flag high after wrong key");
  chk_key_holds:
    assert property (!key_wr ##1 !key_wr |=> $stable(cal_unlocked_o))
    else $error("unlock flag moved alone");
  chk_cfg_loads:
    assert property (cfg_wr |=> {gain_sel_o, update_rate_o, atten_en_o} == $past(cfg_w))
    else $error("config outputs differ from write");
  chk_cfg_holds:
    assert property (!cfg_wr |=> $stable(atten_en_o) && $stable(gain_sel_o))
    else $error("config outputs moved alone");
  chk_rsvd_zero:
    assert property (rd_i && addr_i[15:8] == 8'h22 && addr_i != `OFS_CAL_KEY
                     |=> rdata_o[31:12] == 20'h0)
    else $error("trim upper bits not zero");
  chk_rd_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  chk_dac_settles: assert property (s_calm [*5] |=> $stable(dac_out_o))
    else $error("trimmed code moved with quiet inputs");
endmodule
bind dac_calibration_trim_regs trim_bank_checker u_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .hs_mode_i(hs_mode_i), .dac_code_i(dac_code_i),
  .rdata_o(rdata_o), .dac_out_o(dac_out_o), .gain_sel_o(gain_sel_o),
  .atten_en_o(atten_en_o), .update_rate_o(update_rate_o),
  .cal_unlocked_o(cal_unlocked_o));
`default_nettype wire

/* File: testbench/dac_calibration_trim_regs_tb_top.sv */
/* Self-checking bench for the DAC trim register bank.
   Assumes the design and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "dac_trim_defs.vh"
module dac_calibration_trim_regs_tb_top;
  logic                    mclk_i = 1'b0;
  logic                    sys_rst_i = 1'b1;
  logic [`ADDR_W-1:0]      addr_i = 16'h0000;
  logic [`DATA_W-1:0]      wdata_i = 32'h0;
  logic                    wr_i = 1'b0;
  logic                    rd_i = 1'b0;
  logic                    hs_mode_i = 1'b0;
  logic [`TRIM_W-1:0]      dac_code_i = 12'h800;
  wire logic [`DATA_W-1:0] rdata_o;
  wire logic [`OUT_W-1:0]  dac_out_o;
  wire logic               gain_sel_o;
  wire logic               atten_en_o;
  wire logic [7:0]         update_rate_o;
  wire logic               cal_unlocked_o;
  integer                  num_errors = 0;
  integer                  checks = 0;
  integer                  m_tr [0:4] = '{2048, 0, 0, 0, 0};
  integer                  m_at = 0;
  logic [31:0]             m_key = `CAL_KEY_RST;
  logic                    m_rej = 1'b0;
  logic [31:0]             seed = 32'hd217;
  logic [15:0]             ofs [0:5] = '{`OFS_CAL_KEY, `OFS_GAIN_TRIM, `OFS_ATTEN_LP,
                                         `OFS_NOATTEN_LP, `OFS_ATTEN_HS, `OFS_NOATTEN_HS};
  // 50 ns period
  always #25 mclk_i = ~mclk_i;
  dac_calibration_trim_regs u_dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .hs_mode_i(hs_mode_i), .dac_code_i(dac_code_i),
    .rdata_o(rdata_o), .dac_out_o(dac_out_o), .gain_sel_o(gain_sel_o),
    .atten_en_o(atten_en_o), .update_rate_o(update_rate_o),
    .cal_unlocked_o(cal_unlocked_o));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected read word; unmapped places read zero
  function [31:0] mreg(input [15:0] a);
    integer i;
    begin
      mreg = (a == `OFS_CAL_KEY) ? m_key : 32'h0;
      // Status: sticky refusal above the live unlock state
      if (a == `OFS_CAL_STATUS)
        mreg = {30'h0, m_rej, m_key == `CAL_KEY_UNLOCK};
      for (i = 1; i < 6; i = i + 1)
        if (a == ofs[i]) mreg = m_tr[i-1];
    end
  endfunction
  // Trim arithmetic in half-LSB units, saturated to the output range
  function integer mdac(input integer code, input integer hs);
    integer c, o;
    begin
      c = code - 2048;
      o = m_tr[1 + 2 * hs + (m_at ? 0 : 1)];
      o = (o > 2047) ? o - 4096 : o;
      mdac = 2 * c + ((c * (m_tr[0] - 2048)) >>> 13) + o + 4096;
      mdac = (mdac < 0) ? 0 : (mdac > 8191) ? 8191 : mdac;
    end
  endfunction
  task cmp(input string n, input [31:0] e, input [31:0] s);
    begin
      checks = checks + 1;
      if (s !== e)
      begin
        num_errors = num_errors + 1;
        $display("[ERR] %s exp %h got %h", n, e, s);
      end
    end
  endtask
  // Only gain and high speed trims need the key
  task wr(input [15:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      for (i = 1; i < 6; i = i + 1)
        if (a == ofs[i] && (i == 2 || i == 3 || m_key == `CAL_KEY_UNLOCK))
          m_tr[i-1] = d[11:0];
      // Clear first so a refusal in the same write would still win
      if (a == `OFS_CAL_STATUS && d[1])
        m_rej = 1'b0;
      for (i = 1; i < 6; i = i + 1)
        if (a == ofs[i] && i != 2 && i != 3 && m_key != `CAL_KEY_UNLOCK)
          m_rej = 1'b1;
      m_at = (a == `OFS_FAST_DAC_CFG) ? d[0] : m_at;
      m_key = (a == `OFS_CAL_KEY) ? d : m_key;
    end
  endtask
  task rd(input [15:0] a);
    begin
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      cmp("rdata_o", mreg(a), rdata_o);
    end
  endtask
  task rdall;
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1)
        rd(ofs[i]);
      rd(16'h2004);
      rd(`OFS_CAL_STATUS);
    end
  endtask
  // New random code, then wait out the fixed pipeline depth
  task dchk(input integer hs);
    begin
      seed = lfsr(seed);
      @(posedge mclk_i);
      hs_mode_i <= hs[0];
      dac_code_i <= seed[11:0];
      repeat (5) @(posedge mclk_i);
      #1;
      cmp("dac_out_o", mdac(seed[11:0], hs), {19'h0, dac_out_o});
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    num_errors = num_errors + 1;
    print_verdict;
  end
  initial
  begin : main
    integer g, a, k;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rdall;
    cmp("update_rate_o", 32'h0f, update_rate_o);
    dchk(0);
    for (k = 1; k < 6; k = k + 1)
      wr(ofs[k], 32'hffff_f7ff);
    rdall;
    cmp("cal_unlocked_o", 0, cal_unlocked_o);
    wr(`OFS_CAL_KEY, `CAL_KEY_UNLOCK);
    @(posedge mclk_i);
    #1;
    cmp("cal_unlocked_o", 1, cal_unlocked_o);
    for (k = 1; k < 5; k = k + 1)
      wr(ofs[k+1], {20'hfffff, 12'(48'h800_7ff_fff_001 >> (k * 12 - 12))});
    rdall;
    for (g = 0; g < 3; g = g + 1)
      for (a = 0; a < 2; a = a + 1)
      begin
        wr(`OFS_GAIN_TRIM, g * 32'h800 - g / 2);
        // Every range's offset was calibrated before the range moves
        wr(`OFS_FAST_DAC_CFG, a + 32'h1000 * (g % 2));
        #1;
        cmp("atten_en_o", a, atten_en_o);
        cmp("gain_sel_o", g % 2, gain_sel_o);
        for (k = 0; k < 4; k = k + 1)
          dchk(k % 2);
      end
    wr(`OFS_CAL_KEY, 32'h0);
    wr(`OFS_GAIN_TRIM, 32'h123);
    rdall;
    cmp("cal_unlocked_o", 0, cal_unlocked_o);
    wr(`OFS_CAL_STATUS, 32'h2);
    rd(`OFS_CAL_STATUS);
    print_verdict;
  end
endmodule
`default_nettype wire
